//--- iop_pkg.sv
// Shared constants and types for the parallel I/O port group.
// Assumes a single core clock and an AXI4-Lite register bus with 8-bit addresses.
package iop_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_FIRST = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_PORT_BASE = 8'h10;
	localparam logic [7:0] PORT_STRIDE = 8'h08;
	localparam logic [7:0] ADDR_PORT_END = 8'h40;

	// ------------------------------------------------------------------
	// Port geometry
	// ------------------------------------------------------------------
	localparam int FP_W = 6;
	localparam int NUM_PORTS = 6;
	localparam int PIN_TOTAL = 44;
	localparam int BUS_W = 20;
	localparam int BUS_OFS = 8;
	localparam int PORT_W [NUM_PORTS] = '{8, 8, 8, 4, 8, 8};
	localparam int PORT_OFS [NUM_PORTS] = '{0, 8, 16, 24, 28, 36};

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int BIT_TMR = 1;
	localparam int BIT_OD_LO = 2;
	localparam int BIT_OD_HI = 3;
	localparam int BIT_RX = 4;
	localparam int BIT_TX = 5;
	localparam int BIT_PULLUP_DIS = 7;
	localparam int BIT_PWM_LO = 2;
	localparam logic [7:0] FP_MASK = 8'hbf;
	localparam logic [7:0] FP_RESET = 8'h3f;
	localparam logic [7:0] LAT_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'hff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_MICROPROC,
		MODE_EXT_MCU,
		MODE_MCU,
		MODE_PROT_MCU
	} iop_mode_t;

	// Alternate-function requests from the on-chip peripherals.
	typedef struct packed {
		logic ssp_en;
		logic [1:0] ssp_pull_low;
		logic usart_en;
		logic [1:0] usart_out;
		logic [1:0] usart_oe;
		logic [1:0] pwm_en;
		logic [1:0] pwm_out;
	} iop_periph_t;

endpackage : iop_pkg

//--- iop_sync2.sv
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/1ps
module iop_sync2 #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	always_comb begin
		meta_d = d;
		q_d = meta_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= meta_d;
			q <= q_d;
		end
	end
endmodule : iop_sync2

//--- iop_port_slice.sv
// Pin driver for one port that has a direction register.
// Assumes alternate-function requests come from logic on the same clock.
`timescale 1ns/1ps
module iop_port_slice #(
	parameter int W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] lat,
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] alt_en,
	input wire logic [W-1:0] alt_val,
	input wire logic [W-1:0] alt_drv,
	output logic [W-1:0] pin_out,
	output logic [W-1:0] pin_oen
);
	logic [W-1:0] out_d;
	logic [W-1:0] oen_d;

	// A set direction bit means input. A claiming peripheral overrides it.
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (alt_en[i]) begin
				out_d[i] = alt_val[i];
				oen_d[i] = ~alt_drv[i];
			end else begin
				out_d[i] = lat[i];
				oen_d[i] = dir[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= '0;
			pin_oen <= '1;
		end else begin
			pin_out <= out_d;
			pin_oen <= oen_d;
		end
	end
endmodule : iop_port_slice

//--- iop_port_group.sv
// Parallel I/O port group: the six-bit first port and six ports with direction.
// Assumes peripherals and the system bus controller run on aclk; pins are asynchronous.
//
// Operation
// RQ1: Seven ports, fifty pins; all but the first have direction registers.
// RQ2: Third to fifth ports become system bus in processor or extended modes.
// RQ3: Enabled pulse width, sync serial or serial units take their pins automatically.
// RQ4: Direction bit meaningless while a peripheral drives; software rewrites it afterwards.
// RQ5: Input peripherals leave direction alone and see whatever level the pin carries.
// RQ6: First port is a six-bit latch without a direction register.
// RQ7: Reading the first port returns pin levels, not the latch.
// RQ8: Pin one feeds timer zero; two, three serial; four, five transceiver.
// RQ9: Pins two and three are open drain: zero pulls low, one floats.
// RQ10: Writing the open-drain pins leaves every other first-port pin unchanged.
// RQ11: Software should update a shadow copy, then write the whole first port.
// RQ12: Bits zero to five are pins, six reads zero, seven disables pull-ups.
// RQ13: Every pin level passes two flip-flops before reads or peripheral inputs.
`timescale 1ns/1ps
module iop_port_group (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [iop_pkg::FP_W-1:0] first_port_in,
	output logic [iop_pkg::FP_W-1:0] first_port_out,
	output logic [iop_pkg::FP_W-1:0] first_port_oen,
	input wire logic [iop_pkg::PIN_TOTAL-1:0] port_in,
	output logic [iop_pkg::PIN_TOTAL-1:0] port_out,
	output logic [iop_pkg::PIN_TOTAL-1:0] port_oen,
	input wire logic [1:0] mode_pins,
	input wire iop_pkg::iop_periph_t periph,
	input wire logic [iop_pkg::BUS_W-1:0] bus_out,
	input wire logic [iop_pkg::BUS_W-1:0] bus_oe,
	output logic [iop_pkg::BUS_W-1:0] bus_in,
	output logic bus_mode,
	output logic timer_clk,
	output logic [1:0] ssp_in,
	output logic serial_rx,
	output logic [7:0] pullup_en
);
	localparam int SW = iop_pkg::FP_W + iop_pkg::PIN_TOTAL + 2;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [SW-1:0] sync_q;
	logic [iop_pkg::FP_W-1:0] fp_s;
	logic [iop_pkg::PIN_TOTAL-1:0] pt_s;
	logic [1:0] mode_s;

	iop_sync2 #(.W(SW)) u_sync ( // RQ13
		.aclk(aclk),
		.aresetn(aresetn),
		.d({~mode_pins, port_in, first_port_in}),
		.q(sync_q)
	);
	assign fp_s = sync_q[iop_pkg::FP_W-1:0];
	assign pt_s = sync_q[iop_pkg::FP_W +: iop_pkg::PIN_TOTAL];
	// The strap passes the synchroniser inverted. Its flops then clear to the
	// protected mode, so the bus is never claimed while they fill after reset.
	assign mode_s = ~sync_q[SW-1 -: 2];

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	logic [7:0] fp_q, fp_d;
	logic [7:0] lat_q [iop_pkg::NUM_PORTS];
	logic [7:0] lat_d [iop_pkg::NUM_PORTS];
	logic [7:0] dir_q [iop_pkg::NUM_PORTS];
	logic [7:0] dir_d [iop_pkg::NUM_PORTS];
	logic aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [7:0] wdata_q, wdata_d;
	logic wstrb_q, wstrb_d;
	logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0] bresp_d, rresp_d;
	logic [31:0] rdata_d;
	logic wr_go;
	logic [2:0] widx;

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == iop_pkg::ADDR_FIRST) || (a == iop_pkg::ADDR_STATUS) ||
			((a >= iop_pkg::ADDR_PORT_BASE) && (a < iop_pkg::ADDR_PORT_END) &&
			(a[1:0] == 2'h0));
	endfunction : reg_hit

	function automatic logic [2:0] port_idx(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - iop_pkg::ADDR_PORT_BASE;
		port_idx = rel[5:3];
	endfunction : port_idx

	function automatic logic [7:0] port_mask(input logic [2:0] i);
		port_mask = 8'hff >> (8 - iop_pkg::PORT_W[i]);
	endfunction : port_mask

	// ------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------
	// One write at a time: both readies stay low from their handshake until
	// the response is taken, so address and data may arrive in either order.
	assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
	assign widx = port_idx(awaddr_q);

	always_comb begin
		awready_d = s_axi_awready;
		wready_d = s_axi_wready;
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = s_axi_bvalid;
		bresp_d = s_axi_bresp;
		fp_d = fp_q;
		lat_d = lat_q;
		dir_d = dir_q;
		if (s_axi_awvalid && s_axi_awready) begin
			awready_d = 1'b0;
			aw_full_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wready_d = 1'b0;
			w_full_d = 1'b1;
			wdata_d = s_axi_wdata[7:0];
			wstrb_d = s_axi_wstrb[0];
		end
		if (wr_go) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = reg_hit(awaddr_q) ? iop_pkg::RESP_OKAY : iop_pkg::RESP_SLVERR;
			if (wstrb_q && awaddr_q == iop_pkg::ADDR_FIRST) begin
				// The whole byte lands at once, so the open-drain bits never
				// disturb the others and a shadow-copy write is exact.
				fp_d = wdata_q & iop_pkg::FP_MASK; // RQ10 RQ12 RQ11
			end else if (wstrb_q && reg_hit(awaddr_q) &&
				awaddr_q >= iop_pkg::ADDR_PORT_BASE) begin
				if (awaddr_q[2]) begin
					dir_d[widx] = wdata_q & port_mask(widx); // RQ1 RQ4
				end else begin
					lat_d[widx] = wdata_q & port_mask(widx);
				end
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
			awready_d = 1'b1;
			wready_d = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------
	always_comb begin
		arready_d = s_axi_arready;
		rvalid_d = s_axi_rvalid;
		rdata_d = s_axi_rdata;
		rresp_d = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rdata_d = 32'h0;
			rresp_d = reg_hit(s_axi_araddr) ? iop_pkg::RESP_OKAY : iop_pkg::RESP_SLVERR;
			if (s_axi_araddr == iop_pkg::ADDR_FIRST) begin
				rdata_d[7:0] = {fp_q[iop_pkg::BIT_PULLUP_DIS], 1'b0, fp_s}; // RQ7 RQ12
			end else if (s_axi_araddr == iop_pkg::ADDR_STATUS) begin
				rdata_d[7:0] = {1'b0, periph.pwm_en, periph.usart_en, periph.ssp_en,
					bus_mode, mode_s};
			end else if (reg_hit(s_axi_araddr)) begin
				if (s_axi_araddr[2]) begin
					rdata_d[7:0] = dir_q[port_idx(s_axi_araddr)];
				end else begin
					rdata_d[7:0] = 8'(pt_s >> iop_pkg::PORT_OFS[port_idx(s_axi_araddr)]) &
						port_mask(port_idx(s_axi_araddr));
				end
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Pin and peripheral routing
	// ------------------------------------------------------------------
	logic [iop_pkg::FP_W-1:0] fp_out_d, fp_oen_d;
	logic [iop_pkg::PIN_TOTAL-1:0] alt_en, alt_val, alt_drv;
	logic bus_mode_d, timer_d, rx_d;
	logic [1:0] ssp_d;
	logic [7:0] pullup_d;
	logic [iop_pkg::BUS_W-1:0] bus_in_d;

	always_comb begin
		bus_mode_d = (mode_s == iop_pkg::MODE_MICROPROC) ||
			(mode_s == iop_pkg::MODE_EXT_MCU); // RQ2
		// Pins zero and one are input only; with no direction register the
		// other pins drive only when their latch or peripheral asks.
		fp_out_d = '0;
		fp_oen_d = '1; // RQ6
		if (periph.ssp_en) begin
			fp_oen_d[iop_pkg::BIT_OD_HI -: 2] = ~periph.ssp_pull_low; // RQ3 RQ8
		end else begin
			fp_oen_d[iop_pkg::BIT_OD_HI -: 2] = fp_q[iop_pkg::BIT_OD_HI -: 2]; // RQ9
		end
		if (periph.usart_en) begin
			fp_out_d[iop_pkg::BIT_TX -: 2] = periph.usart_out; // RQ3 RQ8
			fp_oen_d[iop_pkg::BIT_TX -: 2] = ~periph.usart_oe;
		end
		alt_en = '0;
		alt_val = '0;
		alt_drv = '0;
		alt_en[iop_pkg::BIT_PWM_LO +: 2] = periph.pwm_en; // RQ3
		alt_val[iop_pkg::BIT_PWM_LO +: 2] = periph.pwm_out;
		alt_drv[iop_pkg::BIT_PWM_LO +: 2] = 2'h3;
		alt_en[iop_pkg::BUS_OFS +: iop_pkg::BUS_W] = {iop_pkg::BUS_W{bus_mode_d}}; // RQ2
		alt_val[iop_pkg::BUS_OFS +: iop_pkg::BUS_W] = bus_out;
		alt_drv[iop_pkg::BUS_OFS +: iop_pkg::BUS_W] = bus_oe;
		// Peripheral inputs see the synchronised pin, whoever drives it.
		timer_d = fp_s[iop_pkg::BIT_TMR]; // RQ5 RQ8
		ssp_d = fp_s[iop_pkg::BIT_OD_HI -: 2];
		rx_d = fp_s[iop_pkg::BIT_RX];
		bus_in_d = pt_s[iop_pkg::BUS_OFS +: iop_pkg::BUS_W];
		// Pull-ups only on second-port pins set as inputs.
		pullup_d = {8{~fp_q[iop_pkg::BIT_PULLUP_DIS]}} & dir_q[0]; // RQ12
	end

	genvar g;
	generate
		for (g = 0; g < iop_pkg::NUM_PORTS; g++) begin : g_port
			localparam int W = iop_pkg::PORT_W[g];
			localparam int O = iop_pkg::PORT_OFS[g];
			iop_port_slice #(.W(W)) u_slice ( // RQ1
				.aclk(aclk),
				.aresetn(aresetn),
				.lat(lat_q[g][W-1:0]),
				.dir(dir_q[g][W-1:0]),
				.alt_en(alt_en[O +: W]),
				.alt_val(alt_val[O +: W]),
				.alt_drv(alt_drv[O +: W]),
				.pin_out(port_out[O +: W]),
				.pin_oen(port_oen[O +: W])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= iop_pkg::RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= iop_pkg::RESP_OKAY;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= 8'h0;
			wdata_q <= 8'h0;
			wstrb_q <= 1'b0;
			fp_q <= iop_pkg::FP_RESET;
			for (int i = 0; i < iop_pkg::NUM_PORTS; i++) begin
				lat_q[i] <= iop_pkg::LAT_RESET;
				dir_q[i] <= iop_pkg::DIR_RESET & port_mask(3'(i));
			end
			first_port_out <= '0;
			first_port_oen <= '1;
			bus_mode <= 1'b0;
			bus_in <= '0;
			timer_clk <= 1'b0;
			ssp_in <= 2'h0;
			serial_rx <= 1'b0;
			pullup_en <= 8'h0;
		end else begin
			s_axi_awready <= awready_d;
			s_axi_wready <= wready_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp <= bresp_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid <= rvalid_d;
			s_axi_rdata <= rdata_d;
			s_axi_rresp <= rresp_d;
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			fp_q <= fp_d;
			lat_q <= lat_d;
			dir_q <= dir_d;
			first_port_out <= fp_out_d;
			first_port_oen <= fp_oen_d;
			bus_mode <= bus_mode_d;
			bus_in <= bus_in_d;
			timer_clk <= timer_d;
			ssp_in <= ssp_d;
			serial_rx <= rx_d;
			pullup_en <= pullup_d;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_od_drive_low: assert property ( // RQ9
		(!periph.ssp_en && !fp_q[iop_pkg::BIT_OD_LO]) |=>
		(!first_port_oen[iop_pkg::BIT_OD_LO] && !first_port_out[iop_pkg::BIT_OD_LO]))
		else $error("open-drain low pin not pulled low");
	a_od_float_high: assert property ( // RQ9
		(!periph.ssp_en && fp_q[iop_pkg::BIT_OD_HI]) |=> first_port_oen[iop_pkg::BIT_OD_HI])
		else $error("open-drain pin driven while latch is one");
	a_ssp_takes_pins: assert property ( // RQ3
		periph.ssp_en |=> first_port_oen[iop_pkg::BIT_OD_HI -: 2] == ~$past(periph.ssp_pull_low))
		else $error("sync serial unit lost control of its pins");
	a_usart_takes_pins: assert property ( // RQ8
		periph.usart_en |=> (first_port_out[iop_pkg::BIT_TX -: 2] == $past(periph.usart_out)) &&
		(first_port_oen[iop_pkg::BIT_TX -: 2] == ~$past(periph.usart_oe)))
		else $error("serial unit pins not following the unit");
	a_input_only_pins: assert property ( // RQ6
		!periph.usart_en |=> (first_port_oen[1:0] == 2'h3) && (first_port_oen[5:4] == 2'h3))
		else $error("first port pin driven without an owner");
	a_read_pin_level: assert property ( // RQ7
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == iop_pkg::ADDR_FIRST) |=>
		s_axi_rvalid && (s_axi_rdata[5:0] == $past(fp_s)) && !s_axi_rdata[6])
		else $error("first port read does not show pin levels");
	a_write_isolated: assert property ( // RQ10
		(wr_go && wstrb_q && awaddr_q == iop_pkg::ADDR_FIRST) |=>
		(fp_q == ($past(wdata_q) & iop_pkg::FP_MASK)) && (lat_q[0] == $past(lat_q[0])) &&
		s_axi_bvalid)
		else $error("first port write misplaced");
	a_bus_claims_port: assert property ( // RQ2
		bus_mode_d |=> port_oen[iop_pkg::BUS_OFS +: iop_pkg::BUS_W] == ~$past(bus_oe))
		else $error("system bus did not claim its ports");
	a_sync_latency: assert property ( // RQ13
		##3 1 |-> timer_clk == $past(first_port_in[iop_pkg::BIT_TMR], 3))
		else $error("timer clock input not three cycles behind the pin");
	a_pullup_follow: assert property ( // RQ12
		fp_q[iop_pkg::BIT_PULLUP_DIS] |=> pullup_en == 8'h0)
		else $error("pull-ups on while disabled");
	a_dir_input_only: assert property ( // RQ1
		(!bus_mode_d && !alt_en[iop_pkg::PORT_OFS[1]] && dir_q[1][0]) |=>
		port_oen[iop_pkg::PORT_OFS[1]])
		else $error("input-direction pin driven");

endmodule : iop_port_group

//--- iop_pins_model.sv
// Model of the circuitry outside the port pins: sources, pull-ups, floating lines.
// Assumes the bench chooses which pins an outside source drives and to what level.
`timescale 1ns/1ps
module iop_pins_model (
	input wire logic aclk,
	input wire logic [iop_pkg::FP_W-1:0] first_port_out,
	input wire logic [iop_pkg::FP_W-1:0] first_port_oen,
	input wire logic [iop_pkg::PIN_TOTAL-1:0] port_out,
	input wire logic [iop_pkg::PIN_TOTAL-1:0] port_oen,
	input wire logic [7:0] pullup_en,
	input wire logic [iop_pkg::FP_W-1:0] fx_val,
	input wire logic [iop_pkg::FP_W-1:0] fx_en,
	input wire logic [iop_pkg::PIN_TOTAL-1:0] px_val,
	input wire logic [iop_pkg::PIN_TOTAL-1:0] px_en,
	output logic [iop_pkg::FP_W-1:0] first_port_in,
	output logic [iop_pkg::PIN_TOTAL-1:0] port_in
);
	logic float_q = 1'b0;
	// A line nobody holds toggles, so a stale level can never pass for a real one.
	always @(posedge aclk) begin
		float_q <= ~float_q;
	end
	always_comb begin
		for (int i = 0; i < iop_pkg::FP_W; i++) begin
			if (i == 2 || i == 3) begin
				// Wired-and with an external pull-up: either side may pull low.
				first_port_in[i] = first_port_oen[i] && !(fx_en[i] && !fx_val[i]);
			end else begin
				first_port_in[i] = !first_port_oen[i] ? first_port_out[i] :
					(fx_en[i] ? fx_val[i] : float_q);
			end
		end
		for (int i = 0; i < iop_pkg::PIN_TOTAL; i++) begin
			port_in[i] = !port_oen[i] ? port_out[i] : px_en[i] ? px_val[i] :
				(i < 8 && pullup_en[i % 8]) ? 1'b1 : float_q;
		end
	end
endmodule : iop_pins_model

//--- tb.sv
// Self-checking bench for the port group, driven through its AXI4-Lite slave.
// Assumes the pin model above stands on all pins of the port group.
`timescale 1ns/1ps
module tb;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr, shadow;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, mode_pins, ssp_in;
	logic [5:0] first_port_in, first_port_out, first_port_oen, fx_val, fx_en;
	logic [43:0] port_in, port_out, port_oen, px_val, px_en;
	logic [19:0] bus_out, bus_oe, bus_in;
	logic bus_mode, timer_clk, serial_rx;
	logic [7:0] pullup_en;
	iop_pkg::iop_periph_t periph;
	int failures = 0;
	int cmp_count = 0;

	iop_port_group u_iop_port_group (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .first_port_in(first_port_in),
		.first_port_out(first_port_out), .first_port_oen(first_port_oen), .port_in(port_in),
		.port_out(port_out), .port_oen(port_oen), .mode_pins(mode_pins), .periph(periph),
		.bus_out(bus_out), .bus_oe(bus_oe), .bus_in(bus_in), .bus_mode(bus_mode),
		.timer_clk(timer_clk), .ssp_in(ssp_in), .serial_rx(serial_rx), .pullup_en(pullup_en));
	iop_pins_model u_iop_pins_model (.aclk(aclk), .first_port_out(first_port_out),
		.first_port_oen(first_port_oen), .port_out(port_out), .port_oen(port_oen),
		.pullup_en(pullup_en), .fx_val(fx_val), .fx_en(fx_en), .px_val(px_val), .px_en(px_en),
		.first_port_in(first_port_in), .port_in(port_in));

	// ------------------------------------------------------------------
	// Bus tasks and checks
	// ------------------------------------------------------------------
	task automatic chk(input string n, input logic [43:0] e, input logic [43:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wait_n(input int n);
		repeat (n) @(posedge aclk);
	endtask : wait_n

	// Entered just after a rising edge; address and data go out together.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		chk("bresp", er, s_axi_bresp);
		s_axi_bready <= 1'b0;
		// One idle edge, so a following call never raises in this step what was just lowered.
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		chk("rdata", ed, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic end_sim();
		if (failures == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	// ------------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ------------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	initial begin
		wait_n(20000);
		failures++;
		end_sim();
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'h1;
		fx_val = 6'h21;
		fx_en = 6'h33;
		px_val = 44'h0;
		px_en = {44{1'b1}};
		mode_pins = 2'h2;
		periph = '0;
		{bus_out, bus_oe} = 40'h0;
		aresetn = 1'b0;
		wait_n(8);
		aresetn <= 1'b1;
		wait_n(4);
		chk("fp_oen", 6'h3f, first_port_oen);
		rd(iop_pkg::ADDR_FIRST, 32'h2d, iop_pkg::RESP_OKAY);
		// The whole first port is written from a shadow copy, never bit by bit.
		shadow = 8'hf3;
		wr(iop_pkg::ADDR_FIRST, shadow, iop_pkg::RESP_OKAY);
		wait_n(4);
		chk("fp_oen", 6'h33, first_port_oen);
		chk("fp_out", 2'h0, first_port_out[3:2]);
		chk("pullup_en", 8'h00, pullup_en);
		rd(iop_pkg::ADDR_FIRST, 32'ha1, iop_pkg::RESP_OKAY);
		shadow = 8'h37;
		wr(iop_pkg::ADDR_FIRST, shadow, iop_pkg::RESP_OKAY);
		fx_en[2] <= 1'b1;
		wait_n(4);
		chk("fp_oen", 6'h37, first_port_oen);
		chk("pullup_en", 8'hff, pullup_en);
		rd(iop_pkg::ADDR_FIRST, 32'h21, iop_pkg::RESP_OKAY);
		fx_en[2] <= 1'b0;
		fx_val[1] <= 1'b1;
		wait_n(2);
		chk("timer_clk", 1'b0, timer_clk);
		wait_n(3);
		chk("timer_clk", 1'b1, timer_clk);
		chk("ssp_in", 2'h1, ssp_in);
		chk("serial_rx", 1'b0, serial_rx);
		periph.ssp_en <= 1'b1;
		periph.ssp_pull_low <= 2'h2;
		periph.usart_en <= 1'b1;
		periph.usart_oe <= 2'h2;
		periph.usart_out <= 2'h2;
		wait_n(3);
		chk("fp_oen", 6'h17, first_port_oen);
		chk("fp_out", 1'b1, first_port_out[5]);
		periph <= '0;
		wr(iop_pkg::ADDR_PORT_BASE + 8'h04, 8'h0f, iop_pkg::RESP_OKAY);
		wr(iop_pkg::ADDR_PORT_BASE, 8'ha5, iop_pkg::RESP_OKAY);
		wait_n(4);
		chk("port_oen", 8'h0f, port_oen[7:0]);
		chk("port_out", 4'ha, port_out[7:4]);
		chk("pullup_en", 8'h0f, pullup_en);
		rd(iop_pkg::ADDR_PORT_BASE, 32'ha0, iop_pkg::RESP_OKAY);
		periph.pwm_en <= 2'h3;
		periph.pwm_out <= 2'h1;
		wait_n(4);
		rd(iop_pkg::ADDR_PORT_BASE, 32'ha4, iop_pkg::RESP_OKAY);
		rd(iop_pkg::ADDR_PORT_BASE + 8'h04, 32'h0f, iop_pkg::RESP_OKAY);
		periph <= '0;
		wr(8'h2c, 8'hff, iop_pkg::RESP_OKAY);
		rd(8'h2c, 32'h0f, iop_pkg::RESP_OKAY);
		wr(8'h44, 8'h00, iop_pkg::RESP_SLVERR);
		rd(8'h44, 32'h0, iop_pkg::RESP_SLVERR);
		// A write with its low strobe clear is answered but must leave the port alone.
		s_axi_wstrb <= 4'h0;
		wr(iop_pkg::ADDR_FIRST, 8'h00, iop_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		wait_n(3);
		chk("fp_oen", 6'h37, first_port_oen);
		bus_out <= 20'h12345;
		bus_oe <= 20'h0f0f0;
		for (int m = 0; m < 4; m++) begin
			mode_pins <= 2'(m);
			wait_n(5);
			rd(iop_pkg::ADDR_STATUS, {29'h0, m < 2, 2'(m)}, iop_pkg::RESP_OKAY);
			chk("bus_mode", m < 2, bus_mode);
			if (m == 0) begin
				chk("bus_oen", 20'(~bus_oe), port_oen[27:8]);
				chk("bus_in", bus_out & bus_oe, bus_in);
			end
		end
		end_sim();
	end
endmodule : tb
